// ### pkg/hpb_defines.svh
// offsets, field positions, reset values and widths of the host port
`ifndef HPB_DEFINES_SVH
`define HPB_DEFINES_SVH
`define HPB_DATA_W 32
`define HPB_ADDR_LO 2
`define HPB_ADDR_HI 5
`define HPB_ADDR_W 4
`define HPB_DEPTH 16
`define HPB_WORD_RST 32'h0000_0000
`define HPB_ADDR_RST 4'h0
`define HPB_MODE_NONMUX 1'h0
`define HPB_MODE_MUX 1'h1
`endif

// ### pkg/hpb_pkg.sv
// types shared by the host parallel port files
`include "hpb_defines.svh"
package hpb_pkg;
    typedef logic [`HPB_DATA_W-1:0] hpb_word_t;
    typedef logic [`HPB_ADDR_W-1:0] hpb_addr_t;
    typedef logic [`HPB_ADDR_HI:`HPB_ADDR_LO] hpb_pin_addr_t;
    typedef enum logic [2:0] {
        HPB_IDLE = 3'b001,
        HPB_ADDR = 3'b010,
        HPB_ACT = 3'b100
    } hpb_state_t;
endpackage

// ### sim/hpb_host_model.sv
// host processor model driving the parallel port pins
`timescale 1ns/1ps
module hpb_host_model (
    input wire logic clk,
    input wire hpb_pkg::hpb_word_t bus,
    output logic mode,
    output logic cs_b,
    output logic oe_b,
    output logic we_b,
    output logic strobe,
    output hpb_pkg::hpb_pin_addr_t addr_pin,
    output hpb_pkg::hpb_word_t host_data,
    output logic host_en
);
    import hpb_pkg::*;
    // idle levels, bus released
    initial begin
        mode = 1'b0;
        {cs_b, oe_b, we_b} = 3'b111;
        strobe = 1'b0;
        addr_pin = '0;
        host_data = '0;
        host_en = 1'b0;
    end
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one word access, each level held at least 4 cycles for the syncs
    task automatic access(input logic m, input logic wr, input hpb_addr_t a,
                          input hpb_word_t d, output hpb_word_t q);
        q = '0;
        mode <= m;
        idle(4);
        cs_b <= 1'b0;
        strobe <= m;
        host_en <= 1'b1;
        addr_pin <= m ? ~a : a; // wrong on purpose in mode 1
        host_data <= m ? (32'hFFFF_FFC3 | {26'h0, a, 2'h0}) : d;
        idle(4);
        if (m) begin
            strobe <= 1'b0;
            idle(4);
        end
        host_data <= d;
        if (wr) begin
            we_b <= 1'b0;
            idle(4);
            we_b <= 1'b1;
            idle(4);
        end else begin
            host_en <= 1'b0;
            oe_b <= 1'b0;
            idle(6);
            @(negedge clk);
            q = bus;
            idle(1);
            oe_b <= 1'b1;
            idle(4);
        end
        cs_b <= 1'b1;
        host_en <= 1'b0;
        idle(4);
    endtask
endmodule

// ### sim/test_host_parallel_bus_pins.sv
// self-checking bench for the host parallel port
`timescale 1ns/1ps
module test_host_parallel_bus_pins;
    import hpb_pkg::*;
    logic clk;
    logic rst_b;
    logic mode, cs_b, oe_b, we_b, strobe, host_en, host_wr_pulse;
    hpb_pin_addr_t addr_pin;
    hpb_word_t host_data, bus, data_out, data_oe_b, q;
    hpb_addr_t word_addr;
    int n_mismatch = 0;
    int comparisons = 0;
    int n_pulse = 0;
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // wire level: device, host, else inverse of last host value
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            bus[i] = !data_oe_b[i] ? data_out[i]
                   : (host_en ? host_data[i] : ~host_data[i]);
        end
    end
    hpb_host_model host (.clk(clk), .bus(bus), .mode(mode), .cs_b(cs_b),
        .oe_b(oe_b), .we_b(we_b), .strobe(strobe), .addr_pin(addr_pin),
        .host_data(host_data), .host_en(host_en));
    hpb_host_port dut (.clk(clk), .rst_b(rst_b), .bus_mux_select(mode),
        .cs_b(cs_b), .oe_b(oe_b), .we_b(we_b), .latch_strobe(strobe),
        .addr_pin(addr_pin), .data_in(bus), .data_out(data_out),
        .data_oe_b(data_oe_b), .word_addr(word_addr),
        .host_wr_pulse(host_wr_pulse));
    // write pulse tally and bus fight watch
    always @(posedge clk) if (host_wr_pulse === 1'b1) n_pulse++;
    always @(negedge clk) begin
        if (host_en === 1'b1 && rst_b) check(data_oe_b, '1);
    end
    task automatic check(input hpb_word_t seen, input hpb_word_t exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic hpb_word_t pat(input hpb_addr_t a);
        return {8{a}} ^ 32'h5A3C_C3A5;
    endfunction
    task automatic t_mode0();
        hpb_addr_t a;
        for (int i = 0; i < 3; i++) begin
            a = (i == 2) ? 4'hF : hpb_addr_t'(i * 5);
            host.access(1'b0, 1'b1, a, pat(a), q);
            check(32'(word_addr), 32'(a));
        end
        for (int i = 0; i < 3; i++) begin
            a = (i == 2) ? 4'hF : hpb_addr_t'(i * 5);
            host.access(1'b0, 1'b0, a, '0, q);
            check(q, pat(a));
        end
        check(32'(n_pulse), 32'h3);
    endtask
    task automatic t_mode1();
        host.access(1'b1, 1'b1, 4'h9, ~pat(4'h9), q);
        check(32'(word_addr), 32'h9);
        host.access(1'b1, 1'b0, 4'h9, '0, q);
        check(q, ~pat(4'h9));
        host.access(1'b1, 1'b0, 4'h5, '0, q);
        check(q, pat(4'h5));
        check(32'(n_pulse), 32'h4);
    endtask
    task automatic t_release();
        // mode 0 so a held-low we reaches the data phase with oe low
        host.mode <= 1'b0;
        host.oe_b <= 1'b0;
        host.idle(6);
        check(data_oe_b, '1);
        host.cs_b <= 1'b0;
        host.we_b <= 1'b0;
        host.host_en <= 1'b1;
        host.idle(6);
        check(data_oe_b, '1);
        host.cs_b <= 1'b1;
        host.idle(4);
        {host.we_b, host.oe_b, host.host_en} <= 3'b110;
        host.idle(4);
        check(32'(n_pulse), 32'h4);
    endtask
    task automatic finish_test();
        $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        #1000000;
        n_mismatch++;
        finish_test();
    end
    initial begin
        rst_b = 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        host.idle(4);
        t_mode0();
        t_mode1();
        t_release();
        finish_test();
    end
endmodule

// ### verilog/hpb_host_port.sv
// device end of the host parallel address/data port
`timescale 1ns/1ps
`include "hpb_defines.svh"
// How it works
// - mode 0: shared low pins are plain data bits, no address role
// - mode 1: shared pins carry address bits first, data after; bit 2 lsb
// - data bus is 32 bits, 0 to 31, each bit two-way
// - device drives data only while host holds output enable low
// - write enable low means write, high means read
// - mode 1: address latched from shared lines by the latch strobe
// - mode 0: separate address lines sampled on chip select falling
// - word aligned addresses; byte address bits 1 and 0 absent
module hpb_host_port (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic bus_mux_select,
    input wire logic cs_b,
    input wire logic oe_b,
    input wire logic we_b,
    input wire logic latch_strobe,
    input wire hpb_pkg::hpb_pin_addr_t addr_pin,
    input wire hpb_pkg::hpb_word_t data_in,
    output hpb_pkg::hpb_word_t data_out,
    output hpb_pkg::hpb_word_t data_oe_b,
    output hpb_pkg::hpb_addr_t word_addr,
    output logic host_wr_pulse
);
    import hpb_pkg::*;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [4:0] ctl_meta;
    logic [4:0] ctl_sync;
    logic [4:0] ctl_prev;
    hpb_pin_addr_t addr_meta;
    hpb_pin_addr_t addr_sync;
    hpb_word_t data_meta;
    hpb_word_t data_sync;
    hpb_state_t state;
    hpb_state_t next_state;
    hpb_word_t rd_word;
    logic mux_s;
    logic cs_s;
    logic oe_s;
    logic we_s;
    logic ale_s;
    logic cs_fall;
    logic cs_rise;
    logic ale_fall;
    logic ale_rise;
    logic we_rise;
    logic drive;

    // two flops on every pin before use
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctl_meta <= 5'h0E; // idle pins: mode 0, strobe low
            ctl_sync <= 5'h0E;
            ctl_prev <= 5'h0E;
            addr_meta <= `HPB_ADDR_RST;
            addr_sync <= `HPB_ADDR_RST;
            data_meta <= `HPB_WORD_RST;
            data_sync <= `HPB_WORD_RST;
        end else begin
            ctl_meta <= {latch_strobe, we_b, oe_b, cs_b, bus_mux_select};
            ctl_sync <= ctl_meta;
            ctl_prev <= ctl_sync;
            addr_meta <= addr_pin;
            addr_sync <= addr_meta;
            data_meta <= data_in;
            data_sync <= data_meta;
        end
    end

    assign mux_s = ctl_sync[0];
    assign cs_s = ctl_sync[1];
    assign oe_s = ctl_sync[2];
    assign we_s = ctl_sync[3];
    assign ale_s = ctl_sync[4];
    assign cs_fall = ctl_prev[1] && !cs_s;
    assign cs_rise = !ctl_prev[1] && cs_s;
    assign we_rise = !ctl_prev[3] && we_s;
    assign ale_fall = ctl_prev[4] && !ale_s;
    assign ale_rise = !ctl_prev[4] && ale_s;

    // ----------------------------------------------------------------
    // access sequencer
    // ----------------------------------------------------------------
    // idle, address phase (mode 1 only), active data phase
    always_comb begin
        next_state = state;
        unique case (state)
            HPB_IDLE: begin
                if (cs_fall) begin
                    next_state = (mux_s == `HPB_MODE_MUX) ? HPB_ADDR
                                                           : HPB_ACT;
                end
            end
            HPB_ADDR: begin
                if (cs_s) begin
                    next_state = HPB_IDLE;
                end else if (ale_fall) begin
                    next_state = HPB_ACT;
                end
            end
            HPB_ACT: begin
                if (cs_s) begin
                    next_state = HPB_IDLE;
                end else if (mux_s == `HPB_MODE_MUX && ale_rise) begin
                    next_state = HPB_ADDR; // new address phase
                end
            end
            default: next_state = HPB_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= HPB_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // address capture
    // ----------------------------------------------------------------
    // word address only, no byte bits taken
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            word_addr <= `HPB_ADDR_RST;
        end else if (state == HPB_IDLE && cs_fall
                     && mux_s == `HPB_MODE_NONMUX) begin
            word_addr <= addr_sync;
        end else if (state == HPB_ADDR && ale_fall && !cs_s) begin
            word_addr <= data_sync[`HPB_ADDR_HI:`HPB_ADDR_LO];
        end
    end

    // ----------------------------------------------------------------
    // write strobe and store
    // ----------------------------------------------------------------
    // write completes on write enable rising
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            host_wr_pulse <= 1'b0;
        end else begin
            host_wr_pulse <= (state == HPB_ACT) && !cs_s && we_rise;
        end
    end

    hpb_word_mem u_mem (
        .clk(clk),
        .rst_b(rst_b),
        .wr_en((state == HPB_ACT) && !cs_s && we_rise),
        .wr_addr(word_addr),
        .wr_data(data_sync), // all 32 bits
        .rd_addr(word_addr),
        .rd_data(rd_word)
    );

    // ----------------------------------------------------------------
    // data drive
    // ----------------------------------------------------------------
    // drive only in read data phase with oe low
    assign drive = (state == HPB_ACT) && !cs_s && !oe_s && we_s;
    assign data_oe_b = {`HPB_DATA_W{!drive}};

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            data_out <= `HPB_WORD_RST;
        end else begin
            data_out <= rd_word;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_drive_needs_oe: assert property (
        !data_oe_b[0] |-> !oe_s && !cs_s)
        else $error("data driven without oe and cs low");
    a_hiz_on_write: assert property (
        !we_s |-> &data_oe_b)
        else $error("data driven during write");
    a_bus_uniform: assert property (
        (&data_oe_b) || !(|data_oe_b))
        else $error("data lanes enabled unevenly");
    a_nonmux_addr: assert property (
        state == HPB_IDLE && cs_fall && !mux_s
        |=> word_addr == $past(addr_sync))
        else $error("nonmux address not sampled on cs fall");
    a_mux_addr: assert property (
        state == HPB_ADDR && ale_fall && !cs_s
        |=> word_addr == $past(data_sync[5:2]) && state == HPB_ACT)
        else $error("mux address not latched on strobe fall");
    a_mux_no_drive: assert property (
        state == HPB_ADDR |-> &data_oe_b)
        else $error("data driven in address phase");
    a_write_pulse: assert property (
        state == HPB_ACT && !cs_s && we_rise |=> host_wr_pulse)
        else $error("write not completed on we rise");
    a_read_drive: assert property (
        state == HPB_ACT && !cs_s && !oe_s && we_s
        |-> !data_oe_b[31])
        else $error("read not driven");
    a_cs_release: assert property (
        cs_rise && state != HPB_IDLE
        |=> state == HPB_IDLE ##1 &data_oe_b)
        else $error("cs release did not end access");
    a_mode0_direct: assert property (
        state == HPB_IDLE && cs_fall && !mux_s |=> state == HPB_ACT)
        else $error("mode 0 entered address phase");

    c_nonmux_read: cover property (state == HPB_ACT && !mux_s && drive);
    c_mux_write: cover property (host_wr_pulse && mux_s);
    c_mux_read: cover property (state == HPB_ADDR ##[1:20] drive);
endmodule

// ### verilog/hpb_word_mem.sv
// word store behind the host port, registered read data
`timescale 1ns/1ps
`include "hpb_defines.svh"
module hpb_word_mem (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wr_en,
    input wire hpb_pkg::hpb_addr_t wr_addr,
    input wire hpb_pkg::hpb_word_t wr_data,
    input wire hpb_pkg::hpb_addr_t rd_addr,
    output hpb_pkg::hpb_word_t rd_data
);
    import hpb_pkg::*;

    hpb_word_t mem [`HPB_DEPTH];

    // ----------------------------------------------------------------
    // storage entries
    // ----------------------------------------------------------------
    // one write decoder per entry
    genvar i;
    generate
        for (i = 0; i < `HPB_DEPTH; i = i + 1) begin : g_entry
            localparam hpb_addr_t entry_addr = hpb_addr_t'(i);
            always_ff @(posedge clk) begin
                if (wr_en && wr_addr == entry_addr) begin
                    mem[i] <= wr_data;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    // read data from a flop, old value on a same-cycle write
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= `HPB_WORD_RST;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule
